/* File: src/input_sync.sv */
// Purpose: two-stage synchroniser plus edge detect for the four digital inputs
// Assumes: one clock, synchronous active-high reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module input_sync (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // raw pins
    input  wire logic [3:0] pinIn,
    // synchronised level and edges
    output logic      [3:0] pinLevel,
    output logic      [3:0] pinRise,
    output logic      [3:0] pinFall
);
    logic [3:0] stage1_reg;
    logic [3:0] stage2_reg;
    logic [3:0] stage3_reg;

    // RULE22: synchronise then detect
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_reg <= 4'h0;
            stage2_reg <= 4'h0;
            stage3_reg <= 4'h0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign pinLevel = stage2_reg;
    assign pinRise  = stage2_reg & ~stage3_reg;
    assign pinFall  = ~stage2_reg & stage3_reg;
endmodule // input_sync

/* File: src/motion_seq_ctrl.sv */
// Purpose: start, chaining and termination control for the motion sequence operating mode
// Assumes: movement engine and data set table drive done, successor and transition inputs
// Notes:   parameter port is a write strobe plus a read address
//
// Contract
// RULE1: status word bit 10 set when the sequence reaches its end.
// RULE2: local: power stage disable ends the operating mode.
// RULE3: fieldbus: end mode on standstill plus done, wait, halt or error.
// RULE4: local: output zero shows waiting for transition condition.
// RULE5: fieldbus: output zero shows no fault in states 4, 5, 6.
// RULE6: output one shows operating state 6 only.
// RULE7: sequence start chains to named successor after the movement finishes.
// RULE8: configured transition condition holds the successor until it is true.
// RULE9: local: start-sequence input function, default on input three.
// RULE10: data set bits latched only when select confirms them.
// RULE11: no data-set bit inputs assigned: select confirms data set 0.
// RULE12: data set code on inputs zero to three, unconfirmed until select.
// RULE13: start condition 0 rise, 1 fall, 2 high, 3 low; reset 0.
// RULE14: start condition applies to first start after mode activation.
// RULE15: changed start condition takes effect at next movement only.
// RULE16: end choice 0 needs new select, 1 sets data set automatically.
// RULE17: end choice writable only with power stage disabled, effective at once.
// RULE18: fieldbus: report on bus and outputs; local: outputs only.
// RULE19: master requests start with control word bit 4 rising.
// RULE20: master sets control bit 5: 0 single, 1 sequence.
// RULE21: 128 data sets, seven-bit number.
// RULE22: digital inputs synchronised before edge and level detection.
`timescale 1ns/1ps
`include "motion_seq_regs.svh"
module motion_seq_ctrl (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // parameter port
    input  wire logic                   parWrite,
    input  wire logic [15:0]            parAddr,
    input  wire logic [15:0]            parWdata,
    output logic      [15:0]            parRdata,
    // mode and drive state
    input  wire logic                   modeSelected,
    input  wire logic                   fieldbusControl,
    input  wire logic                   powerEnabled,
    input  wire logic [3:0]             opState,
    input  wire logic                   standstill,
    input  wire logic                   haltOrQuickStop,
    input  wire logic                   errorDetected,
    // digital inputs
    input  wire logic [3:0]             pinIn,
    // movement engine and running data set
    input  wire logic                   moveDone,
    input  wire logic                   hasSuccessor,
    input  wire logic [`DS_BITS-1:0]    successorSet,
    input  wire logic                   hasTransition,
    input  wire logic                   transitionMet,
    // fieldbus
    input  wire logic [15:0]            drive_control_word,
    input  wire logic [`DS_BITS-1:0]    busDataSet,
    output logic      [15:0]            drive_status_word,
    // movement launch
    output logic                        launchSet,
    output logic      [`DS_BITS-1:0]    launchNumber,
    output logic                        modeActive,
    // digital outputs
    output logic                        output_line_zero,
    output logic                        output_line_one
);
    logic [1:0]                 startCond_reg;
    logic [1:0]                 condInForce_reg;
    logic                       endChoice_reg;
    logic [15:0]                routing_reg;
    logic [`DS_BITS-1:0]        confirmed_reg;
    logic                       confirmedValid_reg;
    logic                       seqMode_reg;
    logic                       seqEnd_reg;
    logic                       modeActive_reg;
    logic                       ctrlBit4_reg;
    motion_seq_pkg::seq_state_t state_reg;
    motion_seq_pkg::seq_state_t state_next;
    logic [3:0]                 pinLevel;
    logic [3:0]                 pinRise;
    logic [3:0]                 pinFall;
    logic                       localStart;
    logic                       busStart;
    logic                       startReq;
    logic                       armed;
    logic                       selectEvt;
    logic                       modeEnd;
    logic [`DS_BITS-1:0]        selectedCode;
    logic [3:0]                 dsMap;
    logic [1:0]                 selPin;
    logic [1:0]                 startPin;

    function automatic logic inState456(input logic [3:0] s);
        inState456 = (s == `OPSTATE_READY) || (s == `OPSTATE_SWON) || (s == `OPSTATE_ENABLED);
    endfunction

    input_sync u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pinIn    (pinIn),
        .pinLevel (pinLevel),
        .pinRise  (pinRise),
        .pinFall  (pinFall)
    );

    assign dsMap    = routing_reg[`RT_DSMAP_LSB +: 4];
    assign selPin   = routing_reg[`RT_SELPIN_LSB +: 2];
    assign startPin = routing_reg[`RT_STARTPIN_LSB +: 2];
    assign armed    = modeActive_reg && (state_reg == motion_seq_pkg::SEQ_ARMED);

    start_qualifier u_qual (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .cond       (motion_seq_pkg::start_cond_t'(condInForce_reg)),
        .level      (pinLevel[startPin]),
        .rise       (pinRise[startPin]),
        .fall       (pinFall[startPin]),
        .armed      (armed && !fieldbusControl),
        .startPulse (localStart)
    );

    // RULE19: control word bit 4 rising
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlBit4_reg <= 1'b0;
        end else begin
            ctrlBit4_reg <= drive_control_word[`CTRL_START_BIT];
        end
    end
    assign busStart = fieldbusControl && armed && drive_control_word[`CTRL_START_BIT] && !ctrlBit4_reg;
    // RULE9: local start from mapped input
    assign startReq = busStart || localStart;

    // RULE12: code on inputs zero to three, masked by bit map
    always_comb begin
        selectedCode = `DS_ZERO;
        for (int i = 0; i < 4; i++) begin
            selectedCode[i] = pinLevel[i] & dsMap[i];
        end
    end
    assign selectEvt = routing_reg[`RT_SELEN_BIT] && pinRise[selPin];

    // RULE10: latch only on select
    // RULE11: unmapped bits give data set 0
    // RULE16: automatic choice keeps the set confirmed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            confirmed_reg      <= `DS_ZERO;
            confirmedValid_reg <= 1'b0;
        end else if (!fieldbusControl && selectEvt) begin
            confirmed_reg      <= selectedCode;
            confirmedValid_reg <= 1'b1;
        end else if (state_reg == motion_seq_pkg::SEQ_DONE && !endChoice_reg) begin
            confirmedValid_reg <= 1'b0;
        end
    end

    // parameter writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startCond_reg <= `RST_START_COND;
            routing_reg   <= `RST_ROUTING;
        end else if (parWrite) begin
            if (parAddr == `OFS_START_COND) begin
                startCond_reg <= parWdata[1:0];
            end
            if (parAddr == `OFS_ROUTING) begin
                routing_reg <= parWdata;
            end
        end
    end

    // RULE17: end choice locked while powered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            endChoice_reg <= `RST_END_CHOICE;
        end else if (parWrite && parAddr == `OFS_END_CHOICE && !powerEnabled) begin
            endChoice_reg <= parWdata[0];
        end
    end

    // RULE14: load condition on mode activation
    // RULE15: refresh only between movements
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            condInForce_reg <= `RST_START_COND;
        end else if (state_reg != motion_seq_pkg::SEQ_MOVING && state_reg != motion_seq_pkg::SEQ_WAITTR) begin
            condInForce_reg <= startCond_reg;
        end
    end

    // RULE2: local mode ends on power disable
    // RULE3: fieldbus end on standstill plus cause
    always_comb begin
        if (fieldbusControl) begin
            modeEnd = standstill && (haltOrQuickStop || errorDetected ||
                      state_reg == motion_seq_pkg::SEQ_DONE ||
                      state_reg == motion_seq_pkg::SEQ_WAITTR ||
                      state_reg == motion_seq_pkg::SEQ_STOPPED);
        end else begin
            modeEnd = !powerEnabled;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeActive_reg <= 1'b0;
        end else if (modeActive_reg && modeEnd) begin
            modeActive_reg <= 1'b0;
        end else if (!modeActive_reg && modeSelected && powerEnabled) begin
            modeActive_reg <= 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            motion_seq_pkg::SEQ_IDLE: begin
                if (modeActive_reg) begin
                    state_next = motion_seq_pkg::SEQ_ARMED;
                end
            end
            motion_seq_pkg::SEQ_ARMED: begin
                if (startReq && (fieldbusControl || confirmedValid_reg)) begin
                    state_next = motion_seq_pkg::SEQ_MOVING;
                end
            end
            motion_seq_pkg::SEQ_MOVING: begin
                if (haltOrQuickStop || errorDetected) begin
                    state_next = motion_seq_pkg::SEQ_STOPPED;
                end else if (moveDone) begin
                    if (!seqMode_reg || !hasSuccessor) begin
                        state_next = motion_seq_pkg::SEQ_DONE;
                    end else if (hasTransition && !transitionMet) begin
                        state_next = motion_seq_pkg::SEQ_WAITTR;
                    end
                end
            end
            motion_seq_pkg::SEQ_WAITTR: begin
                if (haltOrQuickStop || errorDetected) begin
                    state_next = motion_seq_pkg::SEQ_STOPPED;
                end else if (transitionMet) begin
                    state_next = motion_seq_pkg::SEQ_MOVING;
                end
            end
            motion_seq_pkg::SEQ_DONE, motion_seq_pkg::SEQ_STOPPED: begin
                state_next = motion_seq_pkg::SEQ_ARMED;
            end
            default: begin
                state_next = motion_seq_pkg::SEQ_IDLE;
            end
        endcase
        if (!modeActive_reg) begin
            state_next = motion_seq_pkg::SEQ_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= motion_seq_pkg::SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // RULE7: chain successor after movement
    // RULE8: hold until transition met
    // RULE20: bit 5 selects single or sequence
    // RULE21: seven-bit set number
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            launchSet    <= 1'b0;
            launchNumber <= `DS_ZERO;
            seqMode_reg  <= 1'b0;
        end else begin
            launchSet <= 1'b0;
            if (state_reg == motion_seq_pkg::SEQ_ARMED && state_next == motion_seq_pkg::SEQ_MOVING) begin
                launchSet    <= 1'b1;
                launchNumber <= fieldbusControl ? busDataSet : confirmed_reg;
                seqMode_reg  <= fieldbusControl ? drive_control_word[`CTRL_SEQ_BIT] : 1'b1;
            end else if (state_next == motion_seq_pkg::SEQ_MOVING && (
                         (state_reg == motion_seq_pkg::SEQ_WAITTR) ||
                         (state_reg == motion_seq_pkg::SEQ_MOVING && moveDone))) begin
                launchSet    <= 1'b1;
                launchNumber <= successorSet;
            end
        end
    end

    // RULE1: end-of-sequence flag, cleared on next start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seqEnd_reg <= 1'b0;
        end else if (state_next == motion_seq_pkg::SEQ_DONE && seqMode_reg) begin
            seqEnd_reg <= 1'b1;
        end else if (launchSet || !modeActive_reg) begin
            seqEnd_reg <= 1'b0;
        end
    end

    // RULE18: bus status only under fieldbus control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_status_word <= 16'h0000;
        end else begin
            drive_status_word <= 16'h0000;
            drive_status_word[`STAT_SEQ_END_BIT] <= fieldbusControl && seqEnd_reg;
        end
    end

    // RULE4: start acknowledge while waiting
    // RULE5: no fault in states 4 to 6
    // RULE6: active in state 6
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            output_line_zero <= 1'b0;
            output_line_one  <= 1'b0;
        end else begin
            output_line_zero <= fieldbusControl ? inState456(opState)
                                                : (state_reg == motion_seq_pkg::SEQ_WAITTR);
            output_line_one  <= (opState == `OPSTATE_ENABLED);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeActive <= 1'b0;
        end else begin
            modeActive <= modeActive_reg;
        end
    end

    // read-back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            parRdata <= 16'h0000;
        end else begin
            case (parAddr)
                `OFS_START_COND:   parRdata <= {14'h0000, startCond_reg};
                `OFS_END_CHOICE:   parRdata <= {15'h0000, endChoice_reg};
                `OFS_STATUS_WORD:  parRdata <= {5'h00, seqEnd_reg, 3'h0, launchNumber};
                `OFS_CONTROL_WORD: parRdata <= drive_control_word;
                `OFS_ROUTING:      parRdata <= routing_reg;
                default:           parRdata <= 16'h0000;
            endcase
        end
    end
endmodule // motion_seq_ctrl

/* File: src/motion_seq_pkg.sv */
// Purpose: shared types for motion sequence start control
// Assumes: nothing beyond the header
// Notes:   state and setting enumerations only
package motion_seq_pkg;

    typedef enum logic [1:0] {
        COND_RISE  = 2'b00,
        COND_FALL  = 2'b01,
        COND_HIGH  = 2'b10,
        COND_LOW   = 2'b11
    } start_cond_t;

    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b000,
        SEQ_ARMED   = 3'b001,
        SEQ_MOVING  = 3'b010,
        SEQ_WAITTR  = 3'b011,
        SEQ_DONE    = 3'b100,
        SEQ_STOPPED = 3'b101
    } seq_state_t;

endpackage

/* File: src/motion_seq_regs.svh */
// Purpose: offsets, field positions and reset values for sequence start control
// Assumes: 16-bit parameter port
// Notes:   definitions only
`ifndef MOTION_SEQ_REGS_SVH
`define MOTION_SEQ_REGS_SVH

`define OFS_START_COND      16'h2d10
`define OFS_END_CHOICE      16'h2d12
`define OFS_STATUS_WORD     16'h2d14
`define OFS_CONTROL_WORD    16'h2d16
`define OFS_ROUTING         16'h2d18

`define RST_START_COND      2'h0
`define RST_END_CHOICE      1'h0
`define RST_ROUTING         16'h00c0

`define STAT_SEQ_END_BIT    10
`define CTRL_START_BIT      4
`define CTRL_SEQ_BIT        5

`define OPSTATE_READY       4'h4
`define OPSTATE_SWON        4'h5
`define OPSTATE_ENABLED     4'h6

`define DS_BITS             7
`define DS_ZERO             7'h00

// routing field positions: data-set bit map [3:0], select pin [5:4], start pin [7:6]
`define RT_DSMAP_LSB        0
`define RT_SELPIN_LSB       4
`define RT_STARTPIN_LSB     6
`define RT_SELEN_BIT        8

`endif

/* File: src/start_qualifier.sv */
// Purpose: qualifies a sequence start request by the latched start condition
// Assumes: level and edges from input_sync
// Notes:   level conditions fire once per arming
`timescale 1ns/1ps
module start_qualifier (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // condition in force for the coming movement
    input  wire motion_seq_pkg::start_cond_t cond,
    // synchronised start input
    input  wire logic                       level,
    input  wire logic                       rise,
    input  wire logic                       fall,
    // armed from the controller
    input  wire logic                       armed,
    // qualified start, one cycle
    output logic                            startPulse
);
    logic levelUsed_reg;

    // level conditions fire only once while armed, so one hold is one start per arming
    always_ff @(posedge clk) begin
        if (sys_rst || !armed) begin
            levelUsed_reg <= 1'b0;
        end else if (startPulse) begin
            levelUsed_reg <= 1'b1;
        end
    end

    // RULE13: edge or level choice
    always_comb begin
        case (cond)
            motion_seq_pkg::COND_RISE: startPulse = armed & rise;
            motion_seq_pkg::COND_FALL: startPulse = armed & fall;
            motion_seq_pkg::COND_HIGH: startPulse = armed & level & ~levelUsed_reg;
            motion_seq_pkg::COND_LOW:  startPulse = armed & ~level & ~levelUsed_reg;
            default:                   startPulse = 1'b0;
        endcase
    end
endmodule // start_qualifier

/* File: test/fieldbus_master_model.sv */
// Purpose: fieldbus master issuing data set starts through the control word
// Assumes: control word sampled on rising clk
// Notes:   all other bits stay 0
`timescale 1ns/1ps
module fieldbus_master_model #(
    parameter int HOLD_CYCLES = 3
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // request from the bench
    input  wire logic        go,
    input  wire logic        seqMode,
    // control word to the drive
    output logic      [15:0] controlWord
);
    logic [3:0] holdCnt_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            controlWord <= 16'h0000;
            holdCnt_reg <= 4'h0;
        end else if (go) begin
            controlWord <= {10'h000, seqMode, 5'h00};
            holdCnt_reg <= 4'(HOLD_CYCLES);
        end else if (holdCnt_reg != 4'h0) begin
            controlWord[4] <= 1'b1;
            holdCnt_reg <= holdCnt_reg - 4'h1;
        end else begin
            controlWord[4] <= 1'b0;
        end
    end
endmodule // fieldbus_master_model

/* File: test/motion_seq_ctrl_sva.sv */
// Purpose: port-level checks for motion sequence start control
// Assumes: outputs lag their causes by one or two registered cycles
// Notes:   bound to motion_seq_ctrl below
`timescale 1ns/1ps
module motion_seq_ctrl_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // drive state
    input wire logic        fieldbusControl,
    input wire logic        powerEnabled,
    input wire logic [3:0]  opState,
    input wire logic        standstill,
    // movement engine
    input wire logic        moveDone,
    input wire logic        hasSuccessor,
    input wire logic [6:0]  successorSet,
    input wire logic        hasTransition,
    input wire logic        transitionMet,
    // outputs
    input wire logic [15:0] drive_status_word,
    input wire logic        launchSet,
    input wire logic [6:0]  launchNumber,
    input wire logic        modeActive,
    input wire logic        output_line_zero,
    input wire logic        output_line_one
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_chainEnd;
        moveDone && modeActive;
    endsequence
    sequence s_waitEntry;
        s_chainEnd ##0 (hasSuccessor && hasTransition && !transitionMet);
    endsequence

    property p_seqEnd;
        s_chainEnd ##0 (!hasSuccessor && fieldbusControl) |-> ##2 drive_status_word[10];
    endproperty
    property p_localEnd;
        !fieldbusControl && !powerEnabled |-> ##[1:2] !modeActive;
    endproperty
    property p_busEnd;
        $fell(modeActive) && $past(fieldbusControl, 2) |-> $past(standstill, 2);
    endproperty
    property p_ackWait;
        !fieldbusControl ##0 s_waitEntry |-> ##2 output_line_zero;
    endproperty
    property p_noFault;
        fieldbusControl ##1 fieldbusControl |-> output_line_zero == ($past(opState) inside {4'h4, 4'h5, 4'h6});
    endproperty
    property p_active;
        1'b1 |=> output_line_one == ($past(opState) == 4'h6);
    endproperty
    property p_chain;
        s_chainEnd ##0 (hasSuccessor && !hasTransition) |=> launchSet && launchNumber == $past(successorSet);
    endproperty
    property p_hold;
        s_waitEntry |=> !launchSet;
    endproperty
    property p_release;
        !fieldbusControl && output_line_zero && $rose(transitionMet) |=> launchSet;
    endproperty

    a_seqEnd: assert property (p_seqEnd) else $error("end of sequence bit not set");
    a_localEnd: assert property (p_localEnd) else $error("mode kept with power off");
    a_busEnd: assert property (p_busEnd) else $error("mode ended while moving");
    a_ackWait: assert property (p_ackWait) else $error("start acknowledge missing");
    a_noFault: assert property (p_noFault) else $error("no fault output wrong");
    a_active: assert property (p_active) else $error("active output wrong");
    a_chain: assert property (p_chain) else $error("successor not launched");
    a_hold: assert property (p_hold) else $error("successor launched early");
    a_release: assert property (p_release) else $error("successor not released");
endmodule // motion_seq_ctrl_sva

bind motion_seq_ctrl motion_seq_ctrl_sva chk (.clk, .sys_rst, .fieldbusControl, .powerEnabled, .opState,
    .standstill, .moveDone, .hasSuccessor, .successorSet, .hasTransition, .transitionMet, .drive_status_word,
    .launchSet, .launchNumber, .modeActive, .output_line_zero, .output_line_one);

/* File: test/motion_sequence_start_control_tb.sv */
// Purpose: self-checking bench for motion sequence start control
// Assumes: master model drives the control word
// Notes:   halt and error inputs stay low
`timescale 1ns/1ps
`include "motion_seq_regs.svh"
module motion_sequence_start_control_tb;
    logic        clk, sys_rst, parWrite, modeSelected, fieldbusControl, powerEnabled, standstill, moveDone;
    logic        hasSuccessor, hasTransition, transitionMet, goReq, launchSet, modeActive, outZero, outOne;
    logic [15:0] parAddr, parWdata, parRdata, ctrlWord, statusWord;
    logic [3:0]  opState, pinIn;
    logic [6:0]  successorSet, busDataSet, launchNumber, succ;
    logic [31:0] rng;
    int          fails, compares, cycles, launches;

    motion_seq_ctrl uut (.clk, .sys_rst, .parWrite, .parAddr, .parWdata, .parRdata, .modeSelected,
        .fieldbusControl, .powerEnabled, .opState, .standstill, .haltOrQuickStop(1'b0), .errorDetected(1'b0),
        .pinIn, .moveDone, .hasSuccessor, .successorSet, .hasTransition, .transitionMet,
        .drive_control_word(ctrlWord), .busDataSet, .drive_status_word(statusWord), .launchSet, .launchNumber,
        .modeActive, .output_line_zero(outZero), .output_line_one(outOne));
    fieldbus_master_model fbm (.clk, .sys_rst, .go(goReq), .seqMode(1'b1), .controlWord(ctrlWord));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (launchSet === 1'b1) launches++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic void step();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
    endfunction
    function automatic logic expZero(logic fb, logic [3:0] op);
        return fb && op >= 4'h4 && op <= 4'h6;
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrPar(logic [15:0] a, logic [15:0] d);
        @(posedge clk) {parWrite, parAddr, parWdata} <= {1'b1, a, d};
        @(posedge clk) parWrite <= 1'b0;
    endtask
    task automatic rdPar(string what, logic [15:0] a, logic [15:0] exp);
        @(posedge clk) parAddr <= a;
        tick(3);
        check(what, parRdata, exp);
    endtask
    task automatic waitLaunch(string what, logic [6:0] exp);
        for (int n = 0; n < 20 && launchSet !== 1'b1; n++) @(posedge clk);
        check(what, {launchSet, launchNumber}, {1'b1, exp});
    endtask
    task automatic doneMove(logic s, logic t);
        @(posedge clk) {moveDone, hasSuccessor, hasTransition} <= {1'b1, s, t};
        @(posedge clk) moveDone <= 1'b0;
    endtask

    initial begin
        {parWrite, modeSelected, fieldbusControl, powerEnabled, standstill, moveDone, busDataSet} = '0;
        {hasSuccessor, hasTransition, transitionMet, goReq, parAddr, parWdata, opState, pinIn, successorSet} = '0;
        rng = 32'hfaf1;
        sys_rst = 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(3);
        rdPar("cond reset", `OFS_START_COND, 16'h0000);
        rdPar("choice reset", `OFS_END_CHOICE, 16'h0000);
        rdPar("unmapped", 16'h2d00, 16'h0000);
        for (int c = 3; c >= 0; c--) begin
            wrPar(`OFS_START_COND, 16'(c));
            rdPar("cond", `OFS_START_COND, 16'(c));
        end
        wrPar(`OFS_END_CHOICE, 16'h0001);
        rdPar("choice", `OFS_END_CHOICE, 16'h0001);
        powerEnabled <= 1'b1;
        wrPar(`OFS_END_CHOICE, 16'h0000);
        rdPar("choice powered", `OFS_END_CHOICE, 16'h0001);
        for (int i = 0; i < 24; i++) begin
            step();
            @(posedge clk) {fieldbusControl, opState} <= rng[4:0];
            tick(2);
            check("out one", outOne, opState == 4'h6);
            check("out zero", outZero, expZero(fieldbusControl, opState));
        end
        step();
        @(posedge clk) {fieldbusControl, modeSelected, opState, busDataSet} <= {2'b11, 4'h6, rng[6:0]};
        tick(3);
        @(posedge clk) goReq <= 1'b1;
        @(posedge clk) goReq <= 1'b0;
        waitLaunch("bus start", busDataSet);
        step();
        succ = rng[6:0];
        successorSet <= succ;
        tick(3);
        doneMove(1'b1, 1'b0);
        waitLaunch("successor", succ);
        tick(2);
        standstill <= 1'b1;
        doneMove(1'b0, 1'b0);
        tick(2);
        check("seq end", statusWord[10], 1'b1);
        tick(1);
        check("bus end", modeActive, 1'b0);
        @(posedge clk) {fieldbusControl, powerEnabled} <= 2'b00;
        tick(3);
        check("mode off", modeActive, 1'b0);
        wrPar(`OFS_END_CHOICE, 16'h0000);
        wrPar(`OFS_ROUTING, 16'h01c0);
        powerEnabled <= 1'b1;
        tick(4);
        launches = 0;
        @(posedge clk) pinIn <= 4'h8;
        tick(8);
        check("unconfirmed", launches, 0);
        @(posedge clk) pinIn <= 4'h1;
        tick(4);
        @(posedge clk) pinIn <= 4'h0;
        tick(4);
        @(posedge clk) pinIn <= 4'h8;
        waitLaunch("local start", 7'h00);
        tick(3);
        doneMove(1'b1, 1'b1);
        tick(5);
        check("ack", outZero, 1'b1);
        check("held", launches, 1);
        @(posedge clk) transitionMet <= 1'b1;
        waitLaunch("released", succ);
        @(posedge clk) {transitionMet, powerEnabled} <= 2'b00;
        tick(3);
        check("local end", modeActive, 1'b0);
        end_of_test();
    end
endmodule // motion_sequence_start_control_tb
